/* File: rtl/anp_partner_np_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: Bit 15 reads the received page's more-next-pages flag.
// RULE2: Bit 14 reads whether the partner acknowledged our code word.
// RULE3: Bit 13 reads 1 for message page, 0 for unformatted page.
// RULE4: Bit 12 reads the received acknowledge-2 comply indication.
// RULE5: Bit 11 reads the inverse of the previous exchanged toggle.
// RULE6: Bits 10..0 hold the received code field.
// RULE7: Reset code field value stands for a null page.
// RULE8: Control bit 8 set starts cable test after every link-down event.
// RULE9: All page fields update together per received page; writes ignored.
// RULE10: Reserved control bits read zero and ignore writes.
module anp_partner_np_regs (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Management register access.
    input wire logic [4:0] regAddr,
    input wire logic regWrite,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    // Received partner page from the negotiation logic.
    input wire logic pageValid,
    input wire logic pageMore,
    input wire logic pageAck,
    input wire logic pageMsg,
    input wire logic pageAck2,
    input wire logic pageToggle,
    input wire logic [anp_pkg::ANP_NP_CODE_WIDTH-1:0] pageCode,
    // Link status and cable test start.
    input wire logic linkUp,
    output logic cableTestStart
);
    import anp_pkg::*;

    logic [15:0] partnerNp_r, partnerNp_nxt;
    logic [15:0] ctrlOne_r, ctrlOne_nxt;
    logic linkUpPrev_r, linkUpPrev_nxt;
    logic cableTestStart_r, cableTestStart_nxt;
    logic linkDown;

    // Decode of a write strobe aimed at the control register; shared by the logic and the checks.
    function automatic logic ctrl_write_hit(input logic wrStrobe, input logic [4:0] addr);
        return wrStrobe && (addr == ANP_ADDR_CTRL_ONE);
    endfunction : ctrl_write_hit

    // Link-down event is a falling edge of the link status.
    assign linkDown = linkUpPrev_r && !linkUp;

    // Page capture replaces every field in one cycle, so software never sees a mixed page.
    always_comb begin
        partnerNp_nxt = partnerNp_r;
        if (pageValid) begin
            partnerNp_nxt[ANP_NP_MORE_BIT] = pageMore; // RULE1
            partnerNp_nxt[ANP_NP_ACK_BIT] = pageAck; // RULE2
            partnerNp_nxt[ANP_NP_MSG_BIT] = pageMsg; // RULE3
            partnerNp_nxt[ANP_NP_ACK2_BIT] = pageAck2; // RULE4
            partnerNp_nxt[ANP_NP_TOGGLE_BIT] = ~pageToggle; // RULE5
            partnerNp_nxt[ANP_NP_CODE_MSB:0] = pageCode; // RULE6 RULE9
        end
    end

    // Page register flops; there is no write path, so management writes cannot disturb it.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            partnerNp_r <= ANP_PARTNER_NP_RESET; // RULE7
        end else begin
            partnerNp_r <= partnerNp_nxt; // RULE9
        end
    end

    // Control register keeps only the auto-run enable, so reserved bits can never hold a one.
    always_comb begin
        ctrlOne_nxt = ctrlOne_r;
        if (ctrl_write_hit(regWrite, regAddr)) begin
            ctrlOne_nxt = regWdata & ANP_CTRL_WMASK; // RULE10
        end
    end

    // Control register flops.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrlOne_r <= ANP_CTRL_ONE_RESET;
        end else begin
            ctrlOne_r <= ctrlOne_nxt;
        end
    end

    // Link history and cable test launch; the launch is registered so it is a clean one-cycle pulse.
    always_comb begin
        linkUpPrev_nxt = linkUp;
        cableTestStart_nxt = linkDown && ctrlOne_r[ANP_CTRL_AUTOTDR_BIT]; // RULE8
    end

    // Link history resets to down, so a link that is low just after reset launches nothing.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            linkUpPrev_r <= 1'b0;
            cableTestStart_r <= 1'b0;
        end else begin
            linkUpPrev_r <= linkUpPrev_nxt;
            cableTestStart_r <= cableTestStart_nxt;
        end
    end

    // Read mux; unmapped addresses read as zero.
    always_comb begin
        unique case (regAddr)
            ANP_ADDR_PARTNER_NP: regRdata = partnerNp_r; // RULE9
            ANP_ADDR_CTRL_ONE: regRdata = ctrlOne_r & ANP_CTRL_WMASK; // RULE10
            default: regRdata = 16'h0000;
        endcase
    end

    // The launch pulse leaves straight from its flop.
    assign cableTestStart = cableTestStart_r;

    // The more-pages flag shows the offered value one cycle after the page.
    property p_more;
        @(posedge clock) disable iff (!rst_n) pageValid |=> partnerNp_r[ANP_NP_MORE_BIT] == $past(pageMore);
    endproperty
    a_more: assert property (p_more) else $error("more flag not captured"); // RULE1

    // The acknowledge flag shows the offered value one cycle after the page.
    property p_ack;
        @(posedge clock) disable iff (!rst_n) pageValid |=> partnerNp_r[ANP_NP_ACK_BIT] == $past(pageAck);
    endproperty
    a_ack: assert property (p_ack) else $error("ack not captured"); // RULE2

    // The page type flag shows the offered value one cycle after the page.
    property p_msg;
        @(posedge clock) disable iff (!rst_n) pageValid |=> partnerNp_r[ANP_NP_MSG_BIT] == $past(pageMsg);
    endproperty
    a_msg: assert property (p_msg) else $error("message flag not captured"); // RULE3

    // The comply flag shows the offered value one cycle after the page.
    property p_ack2;
        @(posedge clock) disable iff (!rst_n) pageValid |=> partnerNp_r[ANP_NP_ACK2_BIT] == $past(pageAck2);
    endproperty
    a_ack2: assert property (p_ack2) else $error("ack2 not captured"); // RULE4

    // The toggle bit is stored inverted.
    property p_toggle;
        @(posedge clock) disable iff (!rst_n) pageValid |=> partnerNp_r[ANP_NP_TOGGLE_BIT] != $past(pageToggle);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle not inverted"); // RULE5

    // The code field shows the offered value one cycle after the page.
    property p_code;
        @(posedge clock) disable iff (!rst_n) pageValid |=> partnerNp_r[ANP_NP_CODE_MSB:0] == $past(pageCode);
    endproperty
    a_code: assert property (p_code) else $error("code not captured"); // RULE6

    // Without a new page the register holds its contents.
    property p_hold;
        @(posedge clock) disable iff (!rst_n) !pageValid |=> $stable(partnerNp_r);
    endproperty
    a_hold: assert property (p_hold) else $error("page changed without new page"); // RULE9

    // A management write aimed at the page register leaves it untouched.
    property p_page_wr;
        @(posedge clock) disable iff (!rst_n)
            (regWrite && regAddr == ANP_ADDR_PARTNER_NP && !pageValid) |=> $stable(partnerNp_r);
    endproperty
    a_page_wr: assert property (p_page_wr) else $error("page register took a write"); // RULE9

    // A link drop seen with auto-run enabled launches the cable test on the next cycle.
    property p_tdr;
        @(posedge clock) disable iff (!rst_n)
            (linkUp ##1 (!linkUp && ctrlOne_r[ANP_CTRL_AUTOTDR_BIT])) |=> cableTestStart;
    endproperty
    a_tdr: assert property (p_tdr) else $error("cable test start missing"); // RULE8

    // No launch happens unless a link drop was seen with auto-run enabled.
    property p_tdr_quiet;
        @(posedge clock) disable iff (!rst_n)
            cableTestStart |-> ($past(linkUp, 2) && !$past(linkUp) && $past(ctrlOne_r[ANP_CTRL_AUTOTDR_BIT]));
    endproperty
    a_tdr_quiet: assert property (p_tdr_quiet) else $error("cable test start without link drop"); // RULE8

    // The launch lasts exactly one cycle.
    property p_tdr_pulse;
        @(posedge clock) disable iff (!rst_n) cableTestStart |=> !cableTestStart;
    endproperty
    a_tdr_pulse: assert property (p_tdr_pulse) else $error("cable test start too long"); // RULE8

    // A control write stores the auto-run enable.
    property p_ctrl_wr;
        @(posedge clock) disable iff (!rst_n)
            ctrl_write_hit(regWrite, regAddr) |=>
                ctrlOne_r[ANP_CTRL_AUTOTDR_BIT] == $past(regWdata[ANP_CTRL_AUTOTDR_BIT]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("auto-run enable not stored"); // RULE8

    // Reserved control bits are never stored.
    property p_resv;
        @(posedge clock) disable iff (!rst_n) (ctrlOne_r & ~ANP_CTRL_WMASK) == 16'h0000;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved control bit set"); // RULE10

    // Reserved control bits read as zero.
    property p_rd_resv;
        @(posedge clock) disable iff (!rst_n)
            (regAddr == ANP_ADDR_CTRL_ONE) |-> (regRdata & ~ANP_CTRL_WMASK) == 16'h0000;
    endproperty
    a_rd_resv: assert property (p_rd_resv) else $error("reserved control bit read as one"); // RULE10

    // Addresses outside the two registers read as zero.
    property p_rd_unmapped;
        @(posedge clock) disable iff (!rst_n)
            (regAddr != ANP_ADDR_PARTNER_NP && regAddr != ANP_ADDR_CTRL_ONE) |-> regRdata == 16'h0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped address read nonzero");

    // Right after reset the code field holds the null page.
    property p_null;
        @(posedge clock) $rose(rst_n) |-> partnerNp_r[ANP_NP_CODE_MSB:0] == ANP_NULL_CODE;
    endproperty
    a_null: assert property (p_null) else $error("reset code not null"); // RULE7

    // Main scenarios to be reached.
    c_page: cover property (@(posedge clock) pageValid && pageMsg);
    c_tdr: cover property (@(posedge clock) cableTestStart);
    c_wr: cover property (@(posedge clock) ctrl_write_hit(regWrite, regAddr));
    c_page_wr: cover property (@(posedge clock) regWrite && regAddr == ANP_ADDR_PARTNER_NP);
    c_drop_quiet: cover property (@(posedge clock) linkDown && !ctrlOne_r[ANP_CTRL_AUTOTDR_BIT]);
endmodule : anp_partner_np_regs
`default_nettype wire

/* File: rtl/anp_pkg.sv */
package anp_pkg;
    // Register addresses on the management port.
    localparam logic [4:0] ANP_ADDR_PARTNER_NP = 5'h08;
    localparam logic [4:0] ANP_ADDR_CTRL_ONE = 5'h09;
    // Partner next-page field positions.
    localparam int ANP_NP_MORE_BIT = 15;
    localparam int ANP_NP_ACK_BIT = 14;
    localparam int ANP_NP_MSG_BIT = 13;
    localparam int ANP_NP_ACK2_BIT = 12;
    localparam int ANP_NP_TOGGLE_BIT = 11;
    localparam int ANP_NP_CODE_MSB = 10;
    localparam int ANP_NP_CODE_WIDTH = 11;
    // Control register field position and writable mask.
    localparam int ANP_CTRL_AUTOTDR_BIT = 8;
    localparam logic [15:0] ANP_CTRL_WMASK = 16'h0100;
    // Reset values.
    localparam logic [15:0] ANP_PARTNER_NP_RESET = 16'h0000;
    localparam logic [15:0] ANP_CTRL_ONE_RESET = 16'h0000;
    localparam logic [10:0] ANP_NULL_CODE = 11'h000;
endpackage : anp_pkg

/* File: verification/anp_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module anp_src_model (
    // Bench request and page launched toward the block.
    input wire logic clock,
    input wire logic go,
    input wire logic [15:0] word,
    output logic pageValid = 1'b0,
    output logic [15:0] pageBits = 16'h0000
);
    // One whole page per request; fields churn between pages so stale values never pass.
    always @(negedge clock) begin
        pageValid <= go;
        pageBits <= go ? word : ~pageBits;
    end
endmodule : anp_src_model
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import anp_pkg::*;
    logic clock = 0, rst_n = 0, regWrite = 0, rdEn = 0, go = 0, linkUp = 0, pageValid, cableTestStart;
    logic [4:0] regAddr = 5'h00;
    logic [15:0] regWdata = 16'h0000, word = 16'h0000, regRdata, pageBits, last, expQ[$];
    int n_mismatch = 0, n_checks = 0, pulses;
    // Clock at 25 MHz.
    initial forever #20 clock = ~clock;
    anp_src_model i_src (.clock(clock), .go(go), .word(word), .pageValid(pageValid), .pageBits(pageBits));
    anp_partner_np_regs i_dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
        .regWdata(regWdata), .regRdata(regRdata), .pageValid(pageValid), .pageMore(pageBits[15]),
        .pageAck(pageBits[14]), .pageMsg(pageBits[13]), .pageAck2(pageBits[12]),
        .pageToggle(pageBits[11]), .pageCode(pageBits[10:0]), .linkUp(linkUp), .cableTestStart(cableTestStart));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("FAIL %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(negedge clock) {regAddr, rdEn} <= {a, 1'b1};
        expQ.push_back(e);
        @(negedge clock) rdEn <= 1'b0;
    endtask : rd
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clock) {regAddr, regWrite, regWdata} <= {a, 1'b1, d};
        @(negedge clock) regWrite <= 1'b0;
    endtask : wr
    task automatic pg(input logic [15:0] w);
        @(negedge clock) {go, word} <= {1'b1, w};
        @(negedge clock) go <= 1'b0;
        last = w ^ 16'h0800; // The toggle reads inverted.
    endtask : pg
    // Count start pulses around one link drop; reserved control bits are written as ones.
    task automatic lk(input logic en);
        wr(ANP_ADDR_CTRL_ONE, {7'h7f, en, 8'hff});
        pulses = 0;
        @(negedge clock) linkUp <= 1'b1;
        @(negedge clock) linkUp <= 1'b0;
        repeat (4) @(posedge clock) #1 pulses += int'(cableTestStart);
        check(16'(pulses), {15'h0000, en});
    endtask : lk
    // Compare each read with the oldest noted value mid-cycle, where the read data has settled.
    always @(negedge clock) if (rdEn) check(regRdata, expQ.pop_front());
    // Main sequence.
    initial begin
        void'($urandom(11));
        repeat (4) @(negedge clock);
        rst_n <= 1'b1;
        rd(ANP_ADDR_PARTNER_NP, ANP_PARTNER_NP_RESET);
        rd(ANP_ADDR_CTRL_ONE, ANP_CTRL_ONE_RESET);
        repeat (8) begin
            pg(16'($urandom));
            pg(16'($urandom));
            rd(ANP_ADDR_PARTNER_NP, last);
        end
        wr(ANP_ADDR_PARTNER_NP, ~last);
        rd(ANP_ADDR_PARTNER_NP, last);
        $display("page test done");
        for (int i = 0; i < 4; i++) begin
            lk(i[0]);
            rd(ANP_ADDR_CTRL_ONE, {7'h00, i[0], 8'h00});
        end
        rd(5'h1f, 16'h0000);
        $display("control test done");
        // A reset in mid-run must clear a captured page and a set auto-run enable.
        @(negedge clock) rst_n <= 1'b0;
        repeat (2) @(negedge clock);
        rst_n <= 1'b1;
        rd(ANP_ADDR_PARTNER_NP, ANP_PARTNER_NP_RESET);
        rd(ANP_ADDR_CTRL_ONE, ANP_CTRL_ONE_RESET);
        $display("reset test done");
        wrap_up;
    end
    // Watchdog far beyond the expected run.
    initial begin
        #100000;
        n_mismatch++;
        wrap_up;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
endmodule : tb
`default_nettype wire
